// File: src/fwph_consts.vh
// Purpose: constants for the flash write-protect and pause block
// Assumes: 8 MB array of 128 sectors of 64 kB, 24-bit byte address
// Notes: command codes are ordinary serial flash opcodes
`ifndef FWPH_CONSTS_VH
`define FWPH_CONSTS_VH
`define FWPH_OP_LATCH_SET 8'h06
`define FWPH_OP_LATCH_CLR 8'h04
`define FWPH_OP_REG_WRITE 8'h01
`define FWPH_OP_PAGE_WRITE 8'h02
`define FWPH_OP_QUAD_WRITE 8'h32
`define FWPH_OP_OTP_WRITE 8'h42
`define FWPH_OP_WIPE_64K 8'hD8
`define FWPH_OP_WIPE_4K 8'h20
`define FWPH_OP_WIPE_8K 8'h40
`define FWPH_OP_WIPE_ALL 8'hC7
`define FWPH_SECT_MSB 22
`define FWPH_SECT_LSB 16
`define FWPH_LOCK_ALL 3'h7
`define FWPH_LOCK_RST 3'h0
`define FWPH_BUSY_NORMAL 16'h0400
`define FWPH_BUSY_BOOST 16'h0100
`define FWPH_BITS_PER_BYTE 3'h0
`endif

// File: src/fwph_pin_sync.v
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input from outside the clk_sys domain
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
module fwph_pin_sync (
  clk_sys,
  srst,
  pin_in,
  level_out
);
  parameter RST_VAL = 1'b0;
  input wire clk_sys;
  input wire srst;
  input wire pin_in;
  output reg level_out;
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk_sys) begin
    if (srst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_out <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_out <= s3_q;
    end
  end
endmodule

// File: src/fwph_top.v
// Purpose: write latch, region lock, pin lock, clock count, pause
// Assumes: serial link sampled by clk_sys, mode 0 (sample on rise)
// Notes: array itself is outside; block emits accepted write pulses
`timescale 1ns/1ps
`include "fwph_consts.vh"
module fwph_top (
  clk_sys,
  srst,
  chip_select_n,
  serial_clk,
  serial_in,
  pause_n,
  write_protect_n_boost,
  high_voltage_boost,
  four_lane_cfg,
  lock_origin_sel,
  lock_bits_volatile_sel,
  serial_out_int,
  serial_out,
  serial_out_en_n,
  paused,
  write_latch,
  region_lock,
  status_write_lock,
  busy,
  boost_active,
  array_write_go,
  array_write_op,
  array_write_addr,
  cmd_discarded
);
  input wire clk_sys;
  input wire srst;
  input wire chip_select_n;
  input wire serial_clk;
  input wire serial_in;
  input wire pause_n;
  input wire write_protect_n_boost;
  input wire high_voltage_boost;
  input wire four_lane_cfg;
  input wire lock_origin_sel;
  input wire lock_bits_volatile_sel;
  input wire serial_out_int;
  output reg serial_out;
  output reg serial_out_en_n;
  output reg paused;
  output reg write_latch;
  output reg [2:0] region_lock;
  output reg status_write_lock;
  output reg busy;
  output reg boost_active;
  output reg array_write_go;
  output reg [7:0] array_write_op;
  output reg [23:0] array_write_addr;
  output reg cmd_discarded;

  localparam ST_IDLE = 2'h0;
  localparam ST_OP = 2'h1;
  localparam ST_ADDR = 2'h2;
  localparam ST_DATA = 2'h3;

  wire cs_n_s;
  wire sck_s;
  wire si_s;
  wire pause_n_s;
  wire wp_s;
  wire hv_s;

  reg sck_prev_q;
  reg cs_prev_q;
  reg pause_prev_q;
  reg pause_pend_q;
  reg [1:0] st_q;
  reg [7:0] shift_q;
  reg [2:0] bit_cnt_q;
  reg [4:0] addr_cnt_q;
  reg [7:0] op_q;
  reg [23:0] addr_q;
  reg [7:0] data0_q;
  reg data_seen_q;
  reg [15:0] busy_cnt_q;
  reg vol_done_q;

  // the three-flop filter costs four clk_sys periods of latency, fine
  // against the 320 ns link period
  fwph_pin_sync #(.RST_VAL(1'b1)) u_cs (.clk_sys(clk_sys),
    .srst(srst), .pin_in(chip_select_n), .level_out(cs_n_s));
  fwph_pin_sync #(.RST_VAL(1'b0)) u_sck (.clk_sys(clk_sys),
    .srst(srst), .pin_in(serial_clk), .level_out(sck_s));
  fwph_pin_sync #(.RST_VAL(1'b0)) u_si (.clk_sys(clk_sys),
    .srst(srst), .pin_in(serial_in), .level_out(si_s));
  fwph_pin_sync #(.RST_VAL(1'b1)) u_hold (.clk_sys(clk_sys),
    .srst(srst), .pin_in(pause_n), .level_out(pause_n_s));
  fwph_pin_sync #(.RST_VAL(1'b1)) u_wp (.clk_sys(clk_sys),
    .srst(srst), .pin_in(write_protect_n_boost), .level_out(wp_s));
  fwph_pin_sync #(.RST_VAL(1'b0)) u_hv (.clk_sys(clk_sys),
    .srst(srst), .pin_in(high_voltage_boost), .level_out(hv_s));

  function is_modify;
    input [7:0] op;
    begin
      case (op)
        `FWPH_OP_PAGE_WRITE, `FWPH_OP_QUAD_WRITE, `FWPH_OP_OTP_WRITE,
        `FWPH_OP_WIPE_64K, `FWPH_OP_WIPE_4K, `FWPH_OP_WIPE_8K,
        `FWPH_OP_WIPE_ALL, `FWPH_OP_REG_WRITE: is_modify = 1'b1;
        default: is_modify = 1'b0;
      endcase
    end
  endfunction

  function has_addr;
    input [7:0] op;
    begin
      has_addr = is_modify(op) && op != `FWPH_OP_WIPE_ALL &&
        op != `FWPH_OP_REG_WRITE;
    end
  endfunction

  // lock decode: code 0 locks none, code n locks 2^n sectors, 7 locks all 128
  function sect_locked;
    input [2:0] code;
    input bottom;
    input [6:0] sect;
    reg [7:0] span;
    begin
      span = 8'h00;
      if (code != 3'h0)
        span = 8'h01 << code;
      if (code == `FWPH_LOCK_ALL)
        sect_locked = 1'b1;
      else if (bottom)
        sect_locked = {1'b0, sect} < span;
      else
        sect_locked = {1'b0, sect} >= (8'h80 - span);
    end
  endfunction

  wire quad = four_lane_cfg;
  wire pause_ok = !quad;
  wire sck_rise = sck_s && !sck_prev_q;
  wire sck_fall = !sck_s && sck_prev_q;
  wire cs_rise = cs_n_s && !cs_prev_q;
  wire pause_fall = !pause_n_s && pause_prev_q && pause_ok;
  wire pause_rise = pause_n_s && !pause_prev_q;
  wire pin_lock = status_write_lock && !wp_s && !quad;
  wire live = !cs_n_s && !paused;
  wire [7:0] shift_d = {shift_q[6:0], si_s};
  wire whole = bit_cnt_q == `FWPH_BITS_PER_BYTE;
  wire locked_tgt = (op_q == `FWPH_OP_WIPE_ALL) ? (region_lock != 3'h0) :
    sect_locked(region_lock, lock_origin_sel,
    addr_q[`FWPH_SECT_MSB:`FWPH_SECT_LSB]);

  // pause entry and exit
  always @(posedge clk_sys) begin
    if (srst) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      pause_prev_q <= 1'b1;
      pause_pend_q <= 1'b0;
      paused <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_n_s;
      pause_prev_q <= pause_n_s;
      if (cs_n_s || !pause_ok) begin
        paused <= 1'b0;
        pause_pend_q <= 1'b0;
      end else if (!paused) begin
        if (pause_fall && !sck_s)
          paused <= 1'b1;
        else if (pause_fall)
          pause_pend_q <= 1'b1;
        else if (pause_pend_q && sck_fall) begin
          paused <= !pause_n_s;
          pause_pend_q <= 1'b0;
        end
      end else begin
        if (pause_rise && !sck_s)
          paused <= 1'b0;
        else if (pause_rise)
          pause_pend_q <= 1'b1;
        else if (pause_pend_q && sck_fall) begin
          paused <= !pause_n_s;
          pause_pend_q <= 1'b0;
        end
      end
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      serial_out <= 1'b0;
      serial_out_en_n <= 1'b1;
    end else begin
      serial_out <= serial_out_int;
      serial_out_en_n <= cs_n_s || paused;
    end
  end

  // frame decode; cs rise (paused or not) resets it
  always @(posedge clk_sys) begin
    if (srst) begin
      st_q <= ST_IDLE;
      shift_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      addr_cnt_q <= 5'h00;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      data0_q <= 8'h00;
      data_seen_q <= 1'b0;
    end else if (cs_n_s) begin
      st_q <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      addr_cnt_q <= 5'h00;
      data_seen_q <= 1'b0;
    end else if (live && sck_rise) begin
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      case (st_q)
        ST_IDLE, ST_OP: begin
          st_q <= ST_OP;
          if (bit_cnt_q == 3'h7) begin
            op_q <= shift_d;
            st_q <= has_addr(shift_d) ? ST_ADDR : ST_DATA;
          end
        end
        ST_ADDR: begin
          addr_q <= {addr_q[22:0], si_s};
          addr_cnt_q <= addr_cnt_q + 5'h01;
          if (addr_cnt_q == 5'h17)
            st_q <= ST_DATA;
        end
        ST_DATA: begin
          if (bit_cnt_q == 3'h7 && !data_seen_q) begin
            data0_q <= shift_d;
            data_seen_q <= 1'b1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  wire frame_end = cs_rise && (st_q == ST_DATA);
  wire mod_ok = write_latch && whole && !busy;
  wire reg_ok = !pin_lock;
  wire area_ok = !locked_tgt;

  // latch, lock bits, execution and busy timer
  always @(posedge clk_sys) begin
    if (srst) begin
      write_latch <= 1'b0;
      status_write_lock <= 1'b0;
      region_lock <= `FWPH_LOCK_RST;
      busy <= 1'b0;
      busy_cnt_q <= 16'h0000;
      vol_done_q <= 1'b0;
      boost_active <= 1'b0;
      array_write_go <= 1'b0;
      array_write_op <= 8'h00;
      array_write_addr <= 24'h000000;
      cmd_discarded <= 1'b0;
    end else begin
      array_write_go <= 1'b0;
      cmd_discarded <= 1'b0;
      boost_active <= hv_s && !quad;
      // one shot after reset, so a later written 000 is kept
      vol_done_q <= 1'b1;
      if (lock_bits_volatile_sel && !vol_done_q)
        region_lock <= `FWPH_LOCK_ALL;
      // busy runs on clk_sys, so pause or select never cut it short
      if (busy) begin
        if (busy_cnt_q == 16'h0001) begin
          busy <= 1'b0;
          write_latch <= 1'b0;
        end
        busy_cnt_q <= busy_cnt_q - 16'h0001;
      end
      if (cs_rise && st_q != ST_IDLE && whole && !busy) begin
        if (op_q == `FWPH_OP_LATCH_SET && st_q == ST_DATA)
          write_latch <= 1'b1;
        else if (op_q == `FWPH_OP_LATCH_CLR && st_q == ST_DATA)
          write_latch <= 1'b0;
      end
      if (frame_end && is_modify(op_q)) begin
        if (!mod_ok) begin
          cmd_discarded <= 1'b1;
        end else if (op_q == `FWPH_OP_REG_WRITE) begin
          if (reg_ok && data_seen_q) begin
            status_write_lock <= data0_q[7];
            region_lock <= data0_q[4:2];
          end
          write_latch <= 1'b0;
          cmd_discarded <= !(reg_ok && data_seen_q);
        end else if (area_ok || op_q == `FWPH_OP_OTP_WRITE) begin
          array_write_go <= 1'b1;
          array_write_op <= op_q;
          array_write_addr <= addr_q;
          busy <= 1'b1;
          busy_cnt_q <= (hv_s && !quad) ? `FWPH_BUSY_BOOST :
            `FWPH_BUSY_NORMAL;
        end else begin
          write_latch <= 1'b0;
          cmd_discarded <= 1'b1;
        end
      end
    end
  end
endmodule

// File: bench/fwph_props.sv
// Purpose: port checker for fwph_top
// Assumes: all checked signals live in the clk_sys domain
// Notes: busy length is measured by a counter, too long to unroll
`timescale 1ns/1ps
module fwph_props (
  input wire clk_sys,
  input wire srst,
  input wire write_protect_n_boost,
  input wire four_lane_cfg,
  input wire lock_bits_volatile_sel,
  input wire serial_out_en_n,
  input wire paused,
  input wire write_latch,
  input wire [2:0] region_lock,
  input wire status_write_lock,
  input wire busy,
  input wire boost_active,
  input wire array_write_go,
  input wire cmd_discarded
);
  reg [15:0] busy_len_q;
  reg boost_go_q;
  always @(posedge clk_sys) begin
    busy_len_q <= (srst || !busy) ? 16'h0000 : busy_len_q + 16'h0001;
    if (array_write_go)
      boost_go_q <= boost_active;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_go_had_latch: assert property (
    array_write_go |-> write_latch) else $error("go without latch");
  a_busy_end_clr: assert property (
    $fell(busy) |-> ##[0:2] !write_latch) else $error("latch kept");
  a_busy_length: assert property (
    $fell(busy) |-> busy_len_q == (boost_go_q ? 16'h0100 : 16'h0400))
    else $error("busy length wrong");
  a_pause_release: assert property (
    paused && $past(paused) |-> serial_out_en_n) else $error("driven");
  a_quad_no_pause: assert property (
    $past(four_lane_cfg) && four_lane_cfg |-> !$rose(paused))
    else $error("pause in quad");
  a_quad_no_boost: assert property (
    $past(four_lane_cfg) |-> !boost_active) else $error("boost in quad");
  a_pin_lock_ro: assert property (
    $changed(region_lock) |-> !($past(status_write_lock) &&
    !$past(write_protect_n_boost, 4) && !$past(write_protect_n_boost, 8)
    && !$past(four_lane_cfg))) else $error("locked bits changed");
  a_volatile_load: assert property (
    $fell(srst) && lock_bits_volatile_sel |-> ##[0:3] region_lock == 3'h7)
    else $error("lock bits not loaded");
  c_go: cover property (array_write_go);
  c_discard: cover property (cmd_discarded);
  c_pause: cover property (paused && busy == 1'b0);
endmodule

// File: bench/fwph_host.sv
// Purpose: serial host driving the link pins
// Assumes: link clock 320 ns, mode 0, stands still outside frames
// Notes: data line toggles once deselected so no stale value lingers
`timescale 1ns/1ps
module fwph_host (
  input wire clk_sys,
  output reg chip_select_n,
  output reg serial_clk,
  output reg serial_in,
  output reg pause_n
);
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
    pause_n = 1'b1;
  end
  task automatic half;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse;
    half;
    serial_clk = 1'b1;
    half;
    serial_clk = 1'b0;
  endtask
  // p: bit index after which a pause is held, -1 for none
  task automatic frame(input [39:0] d, input integer n, input integer p);
    integer k;
    pause_n = 1'b1;
    chip_select_n = 1'b0;
    half;
    for (k = n - 1; k >= 0; k--) begin
      serial_in = d[k];
      pulse;
      if (n - 1 - k == p) begin
        pause_n = 1'b0;
        repeat (2) begin
          serial_in = ~serial_in;
          pulse;
        end
        half;
        pause_n = 1'b1;
        half;
      end
    end
    half;
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule

// File: bench/fwph_top_bench.sv
// Purpose: self-checking bench for fwph_top
// Assumes: 25 MHz clk_sys, host model on the link pins
// Notes: lock table rows first, then hand-written awkward cases
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("FAIL %s exp %0h got %0h", nm, e, a); end end
module fwph_top_bench;
  logic clk_sys = 0, srst = 1, high_voltage_boost = 0, four_lane_cfg = 0;
  logic lock_origin_sel = 0, lock_bits_volatile_sel = 1;
  logic write_protect_n_boost = 1, serial_out_int = 0;
  logic got_go = 0, got_dis = 0, saw_pause = 0;
  wire chip_select_n, serial_clk, serial_in, pause_n, serial_out, busy;
  wire serial_out_en_n, paused, write_latch, status_write_lock;
  wire boost_active, array_write_go, cmd_discarded;
  wire [2:0] region_lock;
  wire [7:0] array_write_op;
  wire [23:0] array_write_addr;
  integer n_fail = 0, n_tests = 0, r, i;
  logic [3:0] rc [8] = '{4'h1, 4'h1, 4'h6, 4'h6, 4'h9, 4'h9, 4'hF, 4'h8};
  logic [23:0] ra [8] = '{24'h7E0000, 24'h7DFFFF, 24'h400000, 24'h3FFFFF,
    24'h01FFFF, 24'h020000, 24'h7FFFFF, 24'h000000};
  logic [7:0] ex = 8'hAA;
  fwph_host host_u (.clk_sys(clk_sys), .chip_select_n(chip_select_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .pause_n(pause_n));
  fwph_top dut_u (.clk_sys(clk_sys), .srst(srst),
    .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .pause_n(pause_n),
    .write_protect_n_boost(write_protect_n_boost),
    .high_voltage_boost(high_voltage_boost), .four_lane_cfg(four_lane_cfg),
    .lock_origin_sel(lock_origin_sel),
    .lock_bits_volatile_sel(lock_bits_volatile_sel),
    .serial_out_int(serial_out_int), .serial_out(serial_out),
    .serial_out_en_n(serial_out_en_n), .paused(paused),
    .write_latch(write_latch), .region_lock(region_lock),
    .status_write_lock(status_write_lock), .busy(busy),
    .boost_active(boost_active), .array_write_go(array_write_go),
    .array_write_op(array_write_op), .array_write_addr(array_write_addr),
    .cmd_discarded(cmd_discarded));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (array_write_go === 1'b1) got_go <= 1'b1;
    if (cmd_discarded === 1'b1) got_dis <= 1'b1;
    if (paused === 1'b1) saw_pause <= 1'b1;
  end
  task automatic cmd(input [39:0] d, input integer n, input integer p);
    got_go = 0;
    got_dis = 0;
    host_u.frame(d, n, p);
    repeat (8) @(posedge clk_sys);
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk_sys);
    #1;
    `CHK("busy_end", 1'b0, busy)
  endtask
  task automatic tally_and_finish;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(40 * 60000);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 srst = 0;
    repeat (8) @(posedge clk_sys);
    `CHK("vol_lock", 3'h7, region_lock)
    for (r = 0; r < 8; r++) begin
      lock_origin_sel = rc[r][3];
      cmd(8'h06, 8, -1);
      cmd({8'h01, 3'h0, rc[r][2:0], 2'h0}, 16, -1);
      `CHK("lock", rc[r][2:0], region_lock)
      cmd(8'h06, 8, -1);
      cmd({8'hD8, ra[r]}, 32, -1);
      `CHK("go", ex[r], got_go)
      `CHK("discard", !ex[r], got_dis)
      `CHK("latch", 1'b0, write_latch)
      if (ex[r]) begin
        `CHK("addr", ra[r], array_write_addr)
        `CHK("op", 8'hD8, array_write_op)
      end
    end
    cmd(40'h00D8000000, 32, -1);
    `CHK("no_latch", 1'b1, got_dis)
    cmd(8'h06, 8, -1);
    cmd(40'h01B0000000, 33, -1);
    `CHK("odd_count", 1'b1, got_dis)
    cmd(8'h04, 8, -1);
    `CHK("latch_clr", 1'b0, write_latch)
    // boost applied around the paused and the quad wipe frames
    high_voltage_boost = 1;
    cmd(8'h06, 8, -1);
    cmd(40'h00D8000000, 32, 12);
    `CHK("pause_go", 1'b1, got_go)
    `CHK("saw_pause", 1'b1, saw_pause)
    four_lane_cfg = 1;
    saw_pause = 0;
    cmd(8'h06, 8, -1);
    cmd(40'h00D8000000, 32, 12);
    `CHK("quad_pause", 1'b0, saw_pause)
    four_lane_cfg = 0;
    high_voltage_boost = 0;
    cmd(8'h06, 8, -1);
    cmd(16'h0180, 16, -1);
    write_protect_n_boost = 0;
    cmd(8'h06, 8, -1);
    cmd(16'h011C, 16, -1);
    `CHK("pin_lock", 1'b1, got_dis)
    `CHK("ro_lock", 3'h0, region_lock)
    cmd(8'h06, 8, -1);
    `CHK("latch_set", 1'b1, write_latch)
    // mid-run reset: latch and pin lock must not survive it
    srst = 1;
    repeat (4) @(posedge clk_sys);
    #1 srst = 0;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK("rst_latch", 1'b0, write_latch)
    `CHK("rst_swl", 1'b0, status_write_lock)
    `CHK("rst_lock", 3'h7, region_lock)
    serial_out_int = 1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("so_copy", 1'b1, serial_out)
    `CHK("so_off", 1'b1, serial_out_en_n)
    tally_and_finish;
  end
endmodule
bind fwph_top fwph_props chk_u (.clk_sys(clk_sys), .srst(srst),
  .write_protect_n_boost(write_protect_n_boost),
  .four_lane_cfg(four_lane_cfg),
  .lock_bits_volatile_sel(lock_bits_volatile_sel),
  .serial_out_en_n(serial_out_en_n), .paused(paused),
  .write_latch(write_latch), .region_lock(region_lock),
  .status_write_lock(status_write_lock), .busy(busy),
  .boost_active(boost_active), .array_write_go(array_write_go),
  .cmd_discarded(cmd_discarded));
